// [hdl/dmfs_direct_top.sv]
`timescale 1ns/1ps
module dmfs_direct_top (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// request handshake
	input wire logic req_valid,
	output logic req_ready,
	// picture context
	input wire logic cur_picture_structure_flag,
	input wire logic fut_picture_structure_flag,
	input wire logic fut_intra,
	input wire logic cur_parity,
	input wire logic [dmfs_pkg::MBY_W-1:0] cur_mb_y,
	input wire logic [dmfs_pkg::TR_W-1:0] current_temporal_distance,
	input wire logic [dmfs_pkg::TR_W-1:0] colocated_temporal_distance,
	// co-located macroblock, frame or same-parity field
	input wire logic col_intra,
	input wire logic signed [dmfs_pkg::MV_W-1:0] col_mv_x,
	input wire logic signed [dmfs_pkg::MV_W-1:0] col_mv_y,
	input wire logic [dmfs_pkg::REF_W-1:0] col_ref_idx,
	// co-located macroblock of the first field
	input wire logic f1_intra,
	input wire logic signed [dmfs_pkg::MV_W-1:0] f1_mv_x,
	input wire logic signed [dmfs_pkg::MV_W-1:0] f1_mv_y,
	input wire logic [dmfs_pkg::REF_W-1:0] f1_ref_idx,
	input wire logic [dmfs_pkg::TR_W-1:0] f1_temporal_distance,
	// result
	output logic out_valid,
	output logic [dmfs_pkg::MBY_W-1:0] col_mb_y,
	output logic signed [dmfs_pkg::MV_W-1:0] direct_forward_vector_x,
	output logic signed [dmfs_pkg::MV_W-1:0] direct_forward_vector_y,
	output logic signed [dmfs_pkg::MV_W-1:0] direct_backward_vector_x,
	output logic signed [dmfs_pkg::MV_W-1:0] direct_backward_vector_y,
	output logic [dmfs_pkg::REF_W-1:0] fwd_ref_idx,
	output logic fwd_ref_field,
	output logic fwd_ref_parity,
	output logic bwd_ref_field,
	output logic bwd_ref_parity
);
	localparam int MV_W = dmfs_pkg::MV_W;
	localparam int TR_W = dmfs_pkg::TR_W;
	localparam int MBY_W = dmfs_pkg::MBY_W;
	localparam int REF_W = dmfs_pkg::REF_W;

	dmfs_pkg::dmfs_state_t state_q;
	logic start_q;
	logic signed [MV_W-1:0] mv_x_q;
	logic signed [MV_W-1:0] mv_y_q;
	logic [TR_W-1:0] tr_b_q;
	logic [TR_W-1:0] tr_d_q;
	logic req_ready_q;
	logic out_valid_q;
	logic [MBY_W-1:0] col_mb_y_q;
	logic signed [MV_W-1:0] fwd_x_q;
	logic signed [MV_W-1:0] fwd_y_q;
	logic signed [MV_W-1:0] bwd_x_q;
	logic signed [MV_W-1:0] bwd_y_q;
	logic [REF_W-1:0] fwd_ref_idx_q;
	logic fwd_ref_field_q;
	logic fwd_ref_parity_q;
	logic bwd_ref_field_q;
	logic bwd_ref_parity_q;

	// ****************************************
	// case selection
	// ****************************************
	wire logic cur_fld = cur_picture_structure_flag == dmfs_pkg::STRUCT_FIELD;
	wire logic fut_fld = fut_picture_structure_flag == dmfs_pkg::STRUCT_FIELD;
	wire dmfs_pkg::dmfs_case_t sel_case = cur_fld ? (fut_fld ? dmfs_pkg::CASE_FLD_FLD : dmfs_pkg::CASE_FLD_FRM)
		: (fut_fld ? dmfs_pkg::CASE_FRM_FLD : dmfs_pkg::CASE_FRM_FRM);
	wire logic is_fld_frm = sel_case == dmfs_pkg::CASE_FLD_FRM;
	wire logic is_frm_fld = sel_case == dmfs_pkg::CASE_FRM_FLD;
	wire logic take = req_valid && req_ready_q;
	wire logic both_done = sx_if.done && sy_if.done;

	// ****************************************
	// co-located position
	// ****************************************
	wire logic [MBY_W-1:0] loc_twice = {cur_mb_y[MBY_W-2:0], 1'b0};
	wire logic [MBY_W-1:0] loc_half = {1'b0, cur_mb_y[MBY_W-1:1]};
	wire logic [MBY_W-1:0] loc_sel = is_fld_frm ? loc_twice : (is_frm_fld ? loc_half : cur_mb_y);

	// ****************************************
	// source vector and distances
	// ****************************************
	wire logic src_intra = is_frm_fld ? f1_intra : col_intra;
	wire logic signed [MV_W-1:0] halved_y = col_mv_y >>> 1;
	wire logic signed [MV_W-1:0] first_field_scaled_vector = {f1_mv_y[MV_W-2:0], 1'b0};
	wire logic signed [MV_W-1:0] src_x = is_frm_fld ? f1_mv_x : col_mv_x;
	wire logic signed [MV_W-1:0] src_y = is_frm_fld ? first_field_scaled_vector : (is_fld_frm ? halved_y : col_mv_y);
	wire logic [TR_W-1:0] src_tr_d = is_frm_fld ? f1_temporal_distance : colocated_temporal_distance;
	// distance zero would divide by zero; treated like an intra source
	wire logic zero_vec = fut_intra || src_intra || (src_tr_d == '0);

	// ****************************************
	// reference selection
	// ****************************************
	wire logic [REF_W-1:0] frame_of_field = {1'b0, f1_ref_idx[REF_W-1:1]};
	wire logic [REF_W-1:0] ref_idx_sel = is_frm_fld ? frame_of_field : col_ref_idx;
	wire logic ref_field_sel = cur_fld;
	wire logic fwd_par_sel = cur_parity;
	// field/field backs onto field one, field/frame onto the same parity
	wire logic bwd_par_sel = is_fld_frm ? cur_parity : dmfs_pkg::PARITY_FIRST;

	// ****************************************
	// scaling engines, one per component
	// ****************************************
	dmfs_scale_if sx_if ();
	dmfs_scale_if sy_if ();

	assign sx_if.start = start_q;
	assign sx_if.mv = mv_x_q;
	assign sx_if.tr_b = tr_b_q;
	assign sx_if.tr_d = tr_d_q;
	assign sy_if.start = start_q;
	assign sy_if.mv = mv_y_q;
	assign sy_if.tr_b = tr_b_q;
	assign sy_if.tr_d = tr_d_q;

	dmfs_scaler u_scale_x (
		.clk(clk),
		.rst_n(rst_n),
		.sif(sx_if.engine)
	);

	dmfs_scaler u_scale_y (
		.clk(clk),
		.rst_n(rst_n),
		.sif(sy_if.engine)
	);

	// ****************************************
	// control
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= dmfs_pkg::ST_IDLE;
			req_ready_q <= 1'b0;
			out_valid_q <= 1'b0;
			start_q <= 1'b0;
		end else begin
			out_valid_q <= 1'b0;
			start_q <= 1'b0;
			unique case (state_q)
				dmfs_pkg::ST_IDLE: begin
					req_ready_q <= 1'b1;
					if (take) begin
						req_ready_q <= 1'b0;
						if (zero_vec) begin
							out_valid_q <= 1'b1;
							req_ready_q <= 1'b1;
						end else begin
							start_q <= 1'b1;
							state_q <= dmfs_pkg::ST_START;
						end
					end
				end
				dmfs_pkg::ST_START: begin
					state_q <= dmfs_pkg::ST_WAIT;
				end
				dmfs_pkg::ST_WAIT: begin
					if (both_done) begin
						out_valid_q <= 1'b1;
						req_ready_q <= 1'b1;
						state_q <= dmfs_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// ****************************************
	// request capture
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			col_mb_y_q <= '0;
			fwd_ref_idx_q <= '0;
			fwd_ref_field_q <= 1'b0;
			fwd_ref_parity_q <= 1'b0;
			bwd_ref_field_q <= 1'b0;
			bwd_ref_parity_q <= 1'b0;
			mv_x_q <= '0;
			mv_y_q <= '0;
			tr_b_q <= '0;
			tr_d_q <= '0;
		end else if (take) begin
			col_mb_y_q <= loc_sel;
			fwd_ref_idx_q <= ref_idx_sel;
			fwd_ref_field_q <= ref_field_sel;
			fwd_ref_parity_q <= fwd_par_sel;
			bwd_ref_field_q <= ref_field_sel;
			bwd_ref_parity_q <= bwd_par_sel;
			mv_x_q <= src_x;
			mv_y_q <= src_y;
			tr_b_q <= current_temporal_distance;
			tr_d_q <= src_tr_d;
		end
	end

	// ****************************************
	// result registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fwd_x_q <= '0;
			fwd_y_q <= '0;
			bwd_x_q <= '0;
			bwd_y_q <= '0;
		end else if (take && zero_vec) begin
			fwd_x_q <= '0;
			fwd_y_q <= '0;
			bwd_x_q <= '0;
			bwd_y_q <= '0;
		end else if (state_q == dmfs_pkg::ST_WAIT && both_done) begin
			fwd_x_q <= sx_if.fwd;
			fwd_y_q <= sy_if.fwd;
			bwd_x_q <= sx_if.bwd;
			bwd_y_q <= sy_if.bwd;
		end
	end

	assign req_ready = req_ready_q;
	assign out_valid = out_valid_q;
	assign col_mb_y = col_mb_y_q;
	assign direct_forward_vector_x = fwd_x_q;
	assign direct_forward_vector_y = fwd_y_q;
	assign direct_backward_vector_x = bwd_x_q;
	assign direct_backward_vector_y = bwd_y_q;
	assign fwd_ref_idx = fwd_ref_idx_q;
	assign fwd_ref_field = fwd_ref_field_q;
	assign fwd_ref_parity = fwd_ref_parity_q;
	assign bwd_ref_field = bwd_ref_field_q;
	assign bwd_ref_parity = bwd_ref_parity_q;

	// ****************************************
	// checks
	// ****************************************
	twice_row_a: assert property (@(posedge clk) disable iff (!rst_n)
		take && is_fld_frm |=> col_mb_y == MBY_W'({$past(cur_mb_y), 1'b0}))
		else $error("field over frame row not doubled");

	half_row_a: assert property (@(posedge clk) disable iff (!rst_n)
		take && is_frm_fld |=> col_mb_y == ($past(cur_mb_y) >> 1))
		else $error("frame over field row not halved");

	halved_input_a: assert property (@(posedge clk) disable iff (!rst_n)
		take && is_fld_frm && !zero_vec |=> sy_if.start && (sy_if.mv == ($past(col_mv_y) >>> 1)))
		else $error("vertical vector not halved for scaling");

	doubled_input_a: assert property (@(posedge clk) disable iff (!rst_n)
		take && is_frm_fld && !zero_vec |=> sy_if.mv == MV_W'($past(f1_mv_y) <<< 1) && sx_if.mv == $past(f1_mv_x))
		else $error("first field vector not doubled");

	first_field_dist_a: assert property (@(posedge clk) disable iff (!rst_n)
		take && is_frm_fld |=> tr_d_q == $past(f1_temporal_distance) && tr_b_q == $past(current_temporal_distance))
		else $error("frame over field did not use first field distances");

	same_parity_a: assert property (@(posedge clk) disable iff (!rst_n)
		take && is_fld_frm |=> fwd_ref_field && fwd_ref_parity == $past(cur_parity)
		&& fwd_ref_idx == $past(col_ref_idx) && bwd_ref_parity == $past(cur_parity))
		else $error("field over frame reference parity wrong");

	frame_refs_a: assert property (@(posedge clk) disable iff (!rst_n)
		take && is_frm_fld |=> !fwd_ref_field && !bwd_ref_field && fwd_ref_idx == ($past(f1_ref_idx) >> 1))
		else $error("frame over field reference frame wrong");

	intra_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
		take && zero_vec |=> out_valid && direct_forward_vector_x == 0 && direct_forward_vector_y == 0
		&& direct_backward_vector_x == 0 && direct_backward_vector_y == 0)
		else $error("intra source did not give zero vectors");

	scaled_latency_a: assert property (@(posedge clk) disable iff (!rst_n)
		take && !zero_vec |=> (!out_valid && !req_ready) [*8] ##19 out_valid && req_ready)
		else $error("scaled answer not 27 cycles after request");
endmodule : dmfs_direct_top

// [hdl/dmfs_scaler.sv]
`timescale 1ns/1ps
module dmfs_scaler (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// request and answer
	dmfs_scale_if.engine sif
);
	localparam int MV_W = dmfs_pkg::MV_W;
	localparam int TR_W = dmfs_pkg::TR_W;
	localparam int NUM_W = dmfs_pkg::NUM_W;
	localparam int CNT_W = dmfs_pkg::CNT_W;

	logic busy_q;
	logic done_q;
	logic [CNT_W-1:0] cnt_q;
	logic [TR_W-1:0] div_q;
	logic [NUM_W-1:0] num1_q;
	logic [NUM_W-1:0] num2_q;
	logic [TR_W-1:0] rem1_q;
	logic [TR_W-1:0] rem2_q;
	logic neg1_q;
	logic neg2_q;

	// ****************************************
	// operand preparation
	// ****************************************
	wire logic mv_neg = sif.mv[MV_W-1];
	wire logic [MV_W-1:0] mv_mag = mv_neg ? MV_W'(-sif.mv) : MV_W'(sif.mv);
	wire logic diff_neg = sif.tr_b < sif.tr_d;
	wire logic [TR_W-1:0] diff_mag = diff_neg ? (sif.tr_d - sif.tr_b) : (sif.tr_b - sif.tr_d);
	wire logic [NUM_W-1:0] prod1 = {{TR_W{1'b0}}, mv_mag} * {{MV_W{1'b0}}, sif.tr_b};
	wire logic [NUM_W-1:0] prod2 = {{TR_W{1'b0}}, mv_mag} * {{MV_W{1'b0}}, diff_mag};

	// ****************************************
	// restoring division, both quotients at once
	// ****************************************
	wire logic [TR_W:0] r1_sh = {rem1_q, num1_q[NUM_W-1]};
	wire logic [TR_W:0] r2_sh = {rem2_q, num2_q[NUM_W-1]};
	wire logic ge1 = r1_sh >= {1'b0, div_q};
	wire logic ge2 = r2_sh >= {1'b0, div_q};
	wire logic [TR_W:0] r1_sub = r1_sh - {1'b0, div_q};
	wire logic [TR_W:0] r2_sub = r2_sh - {1'b0, div_q};
	wire logic [TR_W-1:0] rem1_nx = ge1 ? r1_sub[TR_W-1:0] : r1_sh[TR_W-1:0];
	wire logic [TR_W-1:0] rem2_nx = ge2 ? r2_sub[TR_W-1:0] : r2_sh[TR_W-1:0];
	wire logic last = busy_q && (cnt_q == dmfs_pkg::CNT_LAST);
	// truncation toward zero: sign applied to the magnitude quotient
	wire logic [MV_W-1:0] q1 = num1_q[MV_W-1:0];
	wire logic [MV_W-1:0] q2 = num2_q[MV_W-1:0];

	assign sif.fwd = neg1_q ? -q1 : q1;
	assign sif.bwd = neg2_q ? -q2 : q2;
	assign sif.done = done_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
			cnt_q <= '0;
		end else begin
			done_q <= last;
			busy_q <= sif.start | (busy_q & ~last);
			cnt_q <= sif.start ? '0 : cnt_q + CNT_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (sif.start) begin
			div_q <= sif.tr_d;
			num1_q <= prod1;
			num2_q <= prod2;
			rem1_q <= '0;
			rem2_q <= '0;
			neg1_q <= mv_neg;
			neg2_q <= mv_neg ^ diff_neg;
		end else if (busy_q) begin
			num1_q <= {num1_q[NUM_W-2:0], ge1};
			num2_q <= {num2_q[NUM_W-2:0], ge2};
			rem1_q <= rem1_nx;
			rem2_q <= rem2_nx;
		end
	end

	scale_latency_a: assert property (@(posedge clk) disable iff (!rst_n)
		sif.start |-> (!sif.done) [*8] ##18 sif.done ##1 !sif.done)
		else $error("scaler answer not 25 cycles after start");
endmodule : dmfs_scaler

// [shared/dmfs_pkg.sv]
// Overview of operation
// - A field-coded current picture with a frame-coded future reference finds its co-located macroblock at twice its own row.
// - In that field/frame case the co-located vector has its vertical part halved before scaling.
// - In that field/frame case forward = TRb*mv/TRd and backward = (TRb-TRd)*mv/TRd for the current field.
// - In that field/frame case the forward reference is the same-parity field of the co-located macroblock's frame.
// - In that field/frame case the backward reference is the same-parity field of the future reference frame.
// - A frame-coded current picture with a field-coded future reference finds its co-located macroblock at half its row.
// - In that frame/field case only the first-field co-located macroblock feeds vectors and references.
// - In that frame/field case the first-field vector has its vertical part doubled before scaling.
// - In that frame/field case forward = TRb*mv1/TRd1 and backward = (TRb-TRd1)*mv1/TRd1.
// - The current distance in the frame/field case is counted in field intervals to the referenced frame.
// - The first-field distance runs from field one of the future reference to the field its vector points at.
// - In that frame/field case the forward reference is the frame holding the field the first-field vector points at.
// - In that frame/field case the backward reference is the future reference frame itself.
// - An intra future reference or intra co-located macroblock gives zero vectors in both directions.
package dmfs_pkg;
	localparam int MV_W = 16;
	localparam int TR_W = 8;
	localparam int REF_W = 5;
	localparam int MBY_W = 8;
	localparam int NUM_W = MV_W + TR_W;
	localparam int DIV_CYCLES = NUM_W;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DIV_CYCLES - 1);
	localparam logic STRUCT_FRAME = 1'b0;
	localparam logic STRUCT_FIELD = 1'b1;
	localparam logic PARITY_FIRST = 1'b0;

	typedef enum logic [1:0] {
		CASE_FRM_FRM,
		CASE_FLD_FLD,
		CASE_FLD_FRM,
		CASE_FRM_FLD
	} dmfs_case_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_START,
		ST_WAIT
	} dmfs_state_t;
endpackage : dmfs_pkg

// [shared/dmfs_scale_if.sv]
`timescale 1ns/1ps
interface dmfs_scale_if;
	logic start;
	logic signed [dmfs_pkg::MV_W-1:0] mv;
	logic [dmfs_pkg::TR_W-1:0] tr_b;
	logic [dmfs_pkg::TR_W-1:0] tr_d;
	logic done;
	logic signed [dmfs_pkg::MV_W-1:0] fwd;
	logic signed [dmfs_pkg::MV_W-1:0] bwd;

	modport client (output start, output mv, output tr_b, output tr_d, input done, input fwd, input bwd);
	modport engine (input start, input mv, input tr_b, input tr_d, output done, output fwd, output bwd);
endinterface : dmfs_scale_if

// [tb/dmfs_direct_top_tb.sv]
`timescale 1ns/1ps
module dmfs_direct_top_tb;
	logic clk, rst_n, req_valid, req_ready, cur_s, fut_s, fut_intra, cur_parity;
	logic [7:0] cur_mb_y, tr_b, tr_d, f1_td, col_mb_y;
	logic col_intra, f1_intra, out_valid, fwd_ref_field, fwd_ref_parity, bwd_ref_field, bwd_ref_parity;
	logic signed [15:0] col_mv_x, col_mv_y, f1_mv_x, f1_mv_y, fvx, fvy, bvx, bvy;
	logic [4:0] col_ref_idx, f1_ref_idx, fwd_ref_idx;
	int n_errors, checks;

	// ***************************************************
	// clock, reset, watchdog
	// ***************************************************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		#(20 * 2000);
		n_errors++;
		tally_and_finish();
	end

	dmfs_direct_top DUT (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
		.cur_picture_structure_flag(cur_s), .fut_picture_structure_flag(fut_s), .fut_intra(fut_intra),
		.cur_parity(cur_parity), .cur_mb_y(cur_mb_y), .current_temporal_distance(tr_b),
		.colocated_temporal_distance(tr_d), .col_intra(col_intra), .col_mv_x(col_mv_x), .col_mv_y(col_mv_y),
		.col_ref_idx(col_ref_idx), .f1_intra(f1_intra), .f1_mv_x(f1_mv_x), .f1_mv_y(f1_mv_y),
		.f1_ref_idx(f1_ref_idx), .f1_temporal_distance(f1_td), .out_valid(out_valid), .col_mb_y(col_mb_y),
		.direct_forward_vector_x(fvx), .direct_forward_vector_y(fvy), .direct_backward_vector_x(bvx),
		.direct_backward_vector_y(bvy), .fwd_ref_idx(fwd_ref_idx), .fwd_ref_field(fwd_ref_field),
		.fwd_ref_parity(fwd_ref_parity), .bwd_ref_field(bwd_ref_field), .bwd_ref_parity(bwd_ref_parity));

	dmfs_mc_model mc (.clk(clk), .rst_n(rst_n), .out_valid(out_valid), .fwd_x(fvx), .fwd_y(fvy),
		.bwd_x(bvx), .bwd_y(bvy));

	// ***************************************************
	// helpers
	// ***************************************************
	task automatic tally_and_finish();
		if (n_errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// truncating scale, low 16 bits kept
	function automatic logic [15:0] scl(input int b, input int d, input int mv, input bit back);
		longint r;
		r = (longint'(back ? b - d : b) * mv) / d;
		return r[15:0];
	endfunction : scl

	// one request, then wait for the result at the compensation stage
	task automatic go();
		int k, n0;
		n0 = mc.n_seen;
		req_valid = 1'b1;
		k = 0;
		// registered ready seen at the falling edge decides the next take
		while (req_ready !== 1'b1 && k < 40) begin
			@(negedge clk);
			k++;
		end
		@(negedge clk);
		req_valid = 1'b0;
		k = 0;
		while (mc.n_seen == n0 && k < 40) begin
			@(negedge clk);
			k++;
		end
		chk(16'(mc.n_seen - n0), 16'h0001);
	endtask : go

	task automatic chk_vec(input logic [15:0] fx, fy, bx, by);
		chk(mc.fx_q, fx);
		chk(mc.fy_q, fy);
		chk(mc.bx_q, bx);
		chk(mc.by_q, by);
	endtask : chk_vec

	task automatic ctx(input logic c, f, input logic [7:0] y, b, d);
		@(negedge clk);
		cur_s = c;
		fut_s = f;
		cur_mb_y = y;
		tr_b = b;
		tr_d = d;
		fut_intra = 1'b0;
		col_intra = 1'b0;
		f1_intra = 1'b0;
	endtask : ctx

	// ***************************************************
	// scenarios
	// ***************************************************
	task automatic t_fld_frm();
		ctx(1'b1, 1'b0, 8'h85, 8'h03, 8'h04);
		cur_parity = 1'b1;
		col_mv_x = 16'sh000a;
		col_mv_y = -16'sh0007;
		col_ref_idx = 5'h03;
		f1_intra = 1'b1;
		go();
		chk({8'h00, col_mb_y}, 16'h000a);
		chk_vec(scl(3, 4, 10, 0), scl(3, 4, -4, 0), scl(3, 4, 10, 1), scl(3, 4, -4, 1));
		chk({11'h000, fwd_ref_idx}, 16'h0003);
		chk({14'h0000, fwd_ref_field, fwd_ref_parity}, 16'h0003);
		chk({14'h0000, bwd_ref_field, bwd_ref_parity}, 16'h0003);
	endtask : t_fld_frm

	task automatic t_frm_fld();
		ctx(1'b0, 1'b1, 8'h09, 8'h05, 8'h00);
		cur_parity = 1'b0;
		col_intra = 1'b1;
		col_mv_x = 16'sh0100;
		col_ref_idx = 5'h1f;
		f1_mv_x = -16'sh0003;
		f1_mv_y = 16'sh0003;
		f1_ref_idx = 5'h05;
		f1_td = 8'h02;
		go();
		chk({8'h00, col_mb_y}, 16'h0004);
		chk_vec(scl(5, 2, -3, 0), scl(5, 2, 6, 0), scl(5, 2, -3, 1), scl(5, 2, 6, 1));
		chk({11'h000, fwd_ref_idx}, 16'h0002);
		chk({15'h0000, fwd_ref_field}, 16'h0000);
		chk({15'h0000, bwd_ref_field}, 16'h0000);
	endtask : t_frm_fld

	task automatic t_intra();
		// pass 3: zero co-located distance, no intra source
		for (int i = 0; i < 4; i++) begin
			ctx(i == 2 ? 1'b0 : 1'b1, i == 2 ? 1'b1 : 1'b0, 8'h02, 8'h03, i == 3 ? 8'h00 : 8'h04);
			col_mv_x = 16'sh0020;
			col_mv_y = 16'sh0020;
			f1_mv_x = 16'sh0020;
			f1_mv_y = 16'sh0020;
			f1_td = 8'h04;
			fut_intra = (i == 0);
			col_intra = (i == 1);
			f1_intra = (i == 2);
			go();
			chk_vec(16'h0000, 16'h0000, 16'h0000, 16'h0000);
		end
	endtask : t_intra

	task automatic t_plain();
		for (int i = 0; i < 2; i++) begin
			ctx(i[0], i[0], 8'h07, 8'h01, 8'h03);
			col_mv_x = -16'sh0005;
			col_mv_y = 16'sh0007;
			cur_parity = 1'b1;
			go();
			chk_vec(scl(1, 3, -5, 0), scl(1, 3, 7, 0), scl(1, 3, -5, 1), scl(1, 3, 7, 1));
			chk({8'h00, col_mb_y}, 16'h0007);
		end
		chk({15'h0000, bwd_ref_parity}, 16'h0000);
	endtask : t_plain

	// ***************************************************
	// main sequence
	// ***************************************************
	initial begin
		n_errors = 0;
		checks = 0;
		rst_n = 1'b0;
		req_valid = 1'b0;
		cur_s = 1'b0;
		fut_s = 1'b0;
		fut_intra = 1'b0;
		cur_parity = 1'b0;
		cur_mb_y = 8'h00;
		tr_b = 8'h00;
		tr_d = 8'h00;
		col_intra = 1'b0;
		col_mv_x = 16'sh0000;
		col_mv_y = 16'sh0000;
		col_ref_idx = 5'h00;
		f1_intra = 1'b0;
		f1_mv_x = 16'sh0000;
		f1_mv_y = 16'sh0000;
		f1_ref_idx = 5'h00;
		f1_td = 8'h00;
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		t_fld_frm();
		t_frm_fld();
		t_intra();
		t_plain();
		tally_and_finish();
	end
endmodule : dmfs_direct_top_tb

// [tb/dmfs_mc_model.sv]
`timescale 1ns/1ps
// ***************************************************
// motion compensation stage: captures each direct result
// ***************************************************
module dmfs_mc_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// result from the direct-mode block
	input wire logic out_valid,
	input wire logic signed [dmfs_pkg::MV_W-1:0] fwd_x,
	input wire logic signed [dmfs_pkg::MV_W-1:0] fwd_y,
	input wire logic signed [dmfs_pkg::MV_W-1:0] bwd_x,
	input wire logic signed [dmfs_pkg::MV_W-1:0] bwd_y
);
	logic [dmfs_pkg::MV_W-1:0] fx_q, fy_q, bx_q, by_q;
	int n_seen;
	// takes the vectors only in the single cycle that the pulse stands
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			n_seen <= 0;
		end else if (out_valid === 1'b1) begin
			fx_q <= fwd_x;
			fy_q <= fwd_y;
			bx_q <= bwd_x;
			by_q <= bwd_y;
			n_seen <= n_seen + 1;
		end
	end
endmodule : dmfs_mc_model
